// File: verilog/flash_page_ops.v
// Purpose: serial command engine for page read, buffer read/write, page program and page erase
// Assumes: serial pins sampled by clk, link clock well below clk/4
// Notes:   main array and both buffers are plain arrays inside this module
`timescale 1ns/100ps
`include "flash_map.vh"

// Behaviour
// RULE_01: page read is opcode, three address bytes, four dummy bytes, then data out.
// RULE_02: standard mode address is 12-bit page then 9-bit byte offset.
// RULE_03: binary mode address uses upper 12 bits page, lower eight bits byte.
// RULE_04: page read wraps from last byte of the page to its first byte.
// RULE_05: chip select rising ends any read and floats serial output.
// RULE_06: host holds chip select low through header and whole data phase.
// RULE_07: page read reads the array directly and leaves both buffers untouched.
// RULE_08: buffer read opcodes select buffer 1 or 2, independent of the array.
// RULE_09: host keeps slow buffer read opcodes to the lower clock rate.
// RULE_10: buffer address is three bytes with 9-bit or 8-bit offset.
// RULE_11: buffer read needs one dummy byte before data comes out.
// RULE_12: buffer read wraps from buffer end to offset zero.
// RULE_13: buffer write opcodes pick the buffer, offset gives first byte loaded.
// RULE_14: write bytes land at successive wrapping offsets until chip select rises.
// RULE_15: program with erase takes page number padded by don't-care bits.
// RULE_16: program with erase erases page to ones, copies buffer, busy meanwhile.
// RULE_17: program without erase uses the same page address layout.
// RULE_18: program without erase copies buffer without erasing, busy meanwhile.
// RULE_19: host programs without erase only pages it erased first.
// RULE_20: page erase opcode takes the same page address layout.
// RULE_21: page erase sets the whole page to ones, busy meanwhile.
// RULE_22: main memory holds 4096 pages chosen by the 12-bit page number.
// RULE_23: program or erase starts only after opcode and three full address bytes.
module flash_page_ops #(
    parameter ep_cycles  = `EP_TIME_US * `CLK_MHZ,
    parameter p_cycles   = `P_TIME_US * `CLK_MHZ,
    parameter pe_cycles  = `PE_TIME_US * `CLK_MHZ,
    parameter fifo_depth = `FIFO_DEPTH,
    parameter fifo_aw    = 4
) (
    input  wire clk,           // system clock
    input  wire nrst,          // sync reset, active low
    input  wire ce,            // clock enable, freezes all state when low
    input  wire cs_n,          // chip select pin, active low
    input  wire sck,           // serial clock pin
    input  wire si,            // serial data in pin
    input  wire bin_page_mode, // 1 selects 256-byte pages
    output wire so,            // serial data out
    output wire so_oe,         // serial out drive enable
    output wire busy,          // self-timed operation running
    output wire wr_stall       // write fifo full, incoming bytes lost
);
    localparam PAGES     = 4096;
    localparam PLEN      = 264;
    localparam MEM_WORDS = PAGES * PLEN;
    localparam FW        = 18;

    localparam [4:0] E_IDLE  = 5'h01;
    localparam [4:0] E_DRAIN = 5'h02;
    localparam [4:0] E_ERASE = 5'h04;
    localparam [4:0] E_COPY  = 5'h08;
    localparam [4:0] E_HOLD  = 5'h10;

    localparam [23:0] EP_CNT = ep_cycles;
    localparam [23:0] P_CNT  = p_cycles;
    localparam [23:0] PE_CNT = pe_cycles;

    reg [7:0] mem    [0:MEM_WORDS-1];
    reg [7:0] bufmem [0:1023];

    // ----------------------------------------
    // pin sampling and edge detection
    // ----------------------------------------
    wire cs_s;
    wire sck_s;
    wire si_s;
    reg  sck_d_q;
    reg  cs_d_q;

    pin_sync #(
        .width (3)
    ) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .d    ({cs_n, sck, si}),
        .q    ({cs_s, sck_s, si_s})
    );

    wire sck_rise = ~cs_s & sck_s & ~sck_d_q;
    wire sck_fall = ~cs_s & ~sck_s & sck_d_q;
    wire cs_rise  = cs_s & ~cs_d_q;
    wire cs_fall  = ~cs_s & cs_d_q;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    reg  [6:0]  cnt_q;
    reg  [6:0]  shift_q;
    reg  [7:0]  op_q;
    reg  [23:0] addr_q;
    reg         addr_ok_q;
    reg         data_q;
    reg  [8:0]  ptr_q;
    reg  [7:0]  tx_q;
    reg  [2:0]  txbit_q;
    reg         so_q;

    wire [7:0] nb = {shift_q, si_s};

    wire is_pread = (op_q == `OP_PAGE_READ); // RULE_01
    wire rd_b2    = (op_q == `OP_BUF2_READ_FAST) || (op_q == `OP_BUF2_READ_SLOW); // RULE_08
    wire is_bread = (op_q == `OP_BUF1_READ_FAST) || (op_q == `OP_BUF1_READ_SLOW) || rd_b2; // RULE_08
    wire wr_b2    = (op_q == `OP_BUF2_WRITE); // RULE_13
    wire is_bwr   = (op_q == `OP_BUF1_WRITE) || wr_b2; // RULE_13
    wire is_pge   = (op_q == `OP_BUF1_PROG_ERASE) || (op_q == `OP_BUF2_PROG_ERASE); // RULE_15
    wire is_pgn   = (op_q == `OP_BUF1_PROG) || (op_q == `OP_BUF2_PROG); // RULE_17
    wire is_per   = (op_q == `OP_PAGE_ERASE); // RULE_20
    wire pg_b2    = (op_q == `OP_BUF2_PROG_ERASE) || (op_q == `OP_BUF2_PROG);
    wire is_read  = is_pread | is_bread;

    // dummy bytes: four for page read, one for buffer read, none for write
    wire [6:0] hdr_len = is_pread ? `HDR_PAGE_READ :
                         is_bread ? `HDR_BUF_READ : `HDR_ADDR_END; // RULE_01 RULE_11

    wire [8:0]  plen  = bin_page_mode ? `PAGE_LEN_BIN : `PAGE_LEN_STD;
    wire [23:0] a_now = (cnt_q == 7'h1F) ? {addr_q[15:0], nb} : addr_q;

    // the two layouts place page and offset fields differently: page from bit 9 in standard mode, from bit 8 in binary mode
    function [11:0] page_of;
        input [23:0] a;
        input        bin;
        begin
            page_of = bin ? a[`BIN_PAGE_LSB +: `PAGE_NUM_W] : a[`STD_PAGE_LSB +: `PAGE_NUM_W];
        end
    endfunction

    function [8:0] off_of;
        input [23:0] a;
        input        bin;
        input [8:0]  len;
        reg   [8:0]  o;
        begin
            o = bin ? {1'b0, a[7:0]} : a[8:0];
            off_of = (o >= len) ? 9'h000 : o;
        end
    endfunction

    function [8:0] nxt;
        input [8:0] p;
        input [8:0] len;
        begin
            nxt = (p >= len - 9'h001) ? 9'h000 : p + 9'h001;
        end
    endfunction

    function [20:0] base_of;
        input [11:0] pg;
        begin
            base_of = {1'b0, pg, 8'h00} + {6'h00, pg, 3'h0};
        end
    endfunction

    wire [11:0] cur_page  = page_of(addr_q, bin_page_mode); // RULE_02 RULE_03
    wire [8:0]  start_off = off_of(a_now, bin_page_mode, plen); // RULE_10
    wire [8:0]  rd_ptr    = data_q ? ptr_q : start_off;
    wire [20:0] rd_idx    = base_of(cur_page) + {12'h000, rd_ptr};
    wire [9:0]  brd_idx   = {rd_b2, rd_ptr};
    // page read goes straight to the array, buffers are never touched
    wire [7:0]  rd_byte   = is_pread ? mem[rd_idx] : bufmem[brd_idx]; // RULE_07 RULE_08

    wire enter_data = sck_rise & ~data_q & (cnt_q + 7'h01 == hdr_len) & (is_read | is_bwr);

    // ----------------------------------------
    // write fifo between serial input and buffers
    // ----------------------------------------
    wire          f_in_valid = sck_rise & data_q & is_bwr & (cnt_q[2:0] == 3'h7);
    wire          f_in_ready;
    wire          f_out_valid;
    wire          f_out_ready;
    wire [FW-1:0] f_out_data;
    reg  [4:0]    eng_q;
    reg           ebuf_q;
    wire          eng_idle  = (eng_q == E_IDLE);
    wire          eng_drain = (eng_q == E_DRAIN);

    sync_fifo #(
        .width (FW),
        .depth (fifo_depth),
        .aw    (fifo_aw)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   ({wr_b2, ptr_q, nb}),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // hold back bytes for the buffer being programmed so the copy sees a stable image
    assign f_out_ready = eng_idle | eng_drain | (f_out_data[17] != ebuf_q);
    assign wr_stall    = ~f_in_ready;

    always @(posedge clk) begin
        if (ce && f_out_valid && f_out_ready)
            bufmem[f_out_data[17:8]] <= f_out_data[7:0]; // RULE_14
    end

    // ----------------------------------------
    // serial front end
    // ----------------------------------------
    always @(posedge clk) begin
        if (!nrst) begin
            sck_d_q   <= 1'b0;
            cs_d_q    <= 1'b1;
            cnt_q     <= 7'h00;
            shift_q   <= 7'h00;
            op_q      <= 8'h00;
            addr_q    <= 24'h000000;
            addr_ok_q <= 1'b0;
            data_q    <= 1'b0;
            ptr_q     <= 9'h000;
            tx_q      <= 8'h00;
            txbit_q   <= 3'h0;
            so_q      <= 1'b0;
        end else if (ce) begin
            sck_d_q <= sck_s;
            cs_d_q  <= cs_s;
            if (cs_fall || cs_s) begin
                cnt_q     <= 7'h00;
                data_q    <= 1'b0; // RULE_05
                txbit_q   <= 3'h0;
                so_q      <= 1'b0;
                if (cs_fall)
                    addr_ok_q <= 1'b0;
            end else if (sck_rise) begin
                shift_q <= nb[6:0];
                cnt_q   <= cnt_q + 7'h01;
                if (!addr_ok_q && cnt_q == 7'h07)
                    op_q <= nb;
                if (!addr_ok_q && cnt_q[2:0] == 3'h7 && cnt_q != 7'h07)
                    addr_q <= {addr_q[15:0], nb};
                if (cnt_q == 7'h1F)
                    addr_ok_q <= 1'b1; // RULE_23
                if (enter_data) begin
                    data_q <= 1'b1;
                    if (is_read) begin
                        tx_q  <= rd_byte; // RULE_01 RULE_11
                        ptr_q <= nxt(start_off, plen);
                    end else begin
                        ptr_q <= start_off; // RULE_13
                    end
                end else if (f_in_valid) begin
                    ptr_q <= nxt(ptr_q, plen); // RULE_14
                end
            end else if (sck_fall && data_q && is_read) begin
                so_q    <= tx_q[7];
                txbit_q <= txbit_q + 3'h1;
                if (txbit_q == 3'h7) begin
                    tx_q  <= rd_byte;
                    ptr_q <= nxt(ptr_q, plen); // RULE_04 RULE_12
                end else begin
                    tx_q <= {tx_q[6:0], 1'b0};
                end
            end
        end
    end

    assign so    = so_q;
    assign so_oe = data_q & ~cs_s & is_read; // RULE_05

    // ----------------------------------------
    // self-timed program and erase engine
    // ----------------------------------------
    reg  [11:0] epage_q;
    reg         do_erase_q;
    reg         do_copy_q;
    reg  [8:0]  eidx_q;
    reg  [8:0]  elen_q;
    reg  [23:0] timer_q;

    wire [20:0] e_idx   = base_of(epage_q) + {12'h000, eidx_q}; // RULE_22
    wire [7:0]  src     = bufmem[{ebuf_q, eidx_q}];
    wire        pe_cmd  = is_pge | is_pgn | is_per;
    wire        start   = cs_rise & addr_ok_q & pe_cmd & eng_idle; // RULE_23

    assign busy = ~eng_idle; // RULE_16 RULE_18 RULE_21

    always @(posedge clk) begin
        if (!nrst) begin
            eng_q      <= E_IDLE;
            epage_q    <= 12'h000;
            ebuf_q     <= 1'b0;
            do_erase_q <= 1'b0;
            do_copy_q  <= 1'b0;
            eidx_q     <= 9'h000;
            elen_q     <= `PAGE_LEN_STD;
            timer_q    <= 24'h000000;
        end else if (ce) begin
            if (!eng_idle && timer_q != 24'h000000)
                timer_q <= timer_q - 24'h000001;
            case (eng_q)
                E_IDLE: begin
                    if (start) begin
                        epage_q    <= cur_page; // RULE_15 RULE_17 RULE_20
                        ebuf_q     <= pg_b2;
                        do_erase_q <= is_pge | is_per;
                        do_copy_q  <= is_pge | is_pgn;
                        elen_q     <= plen;
                        eidx_q     <= 9'h000;
                        timer_q    <= is_per ? PE_CNT : (is_pge ? EP_CNT : P_CNT);
                        eng_q      <= E_DRAIN;
                    end
                end
                E_DRAIN: begin
                    // earlier buffer writes still queued must land before the copy
                    if (!f_out_valid)
                        eng_q <= do_erase_q ? E_ERASE : E_COPY;
                end
                E_ERASE: begin
                    mem[e_idx] <= `ERASED_BYTE; // RULE_16 RULE_21
                    if (eidx_q == `PAGE_LEN_STD - 9'h001) begin
                        eidx_q <= 9'h000;
                        eng_q  <= do_copy_q ? E_COPY : E_HOLD;
                    end else begin
                        eidx_q <= eidx_q + 9'h001;
                    end
                end
                E_COPY: begin
                    // programming can only clear bits, so an unerased page ends up ANDed
                    mem[e_idx] <= mem[e_idx] & src; // RULE_16 RULE_18
                    if (eidx_q == elen_q - 9'h001) begin
                        eidx_q <= 9'h000;
                        eng_q  <= E_HOLD;
                    end else begin
                        eidx_q <= eidx_q + 9'h001;
                    end
                end
                E_HOLD: begin
                    if (timer_q == 24'h000000)
                        eng_q <= E_IDLE;
                end
                default: begin
                    eng_q <= E_IDLE;
                end
            endcase
        end
    end
endmodule

// File: common/flash_map.vh
// Purpose: shared constants for the serial flash page and buffer command block
// Assumes: 100 MHz system clock, serial modes 0 and 3
// Notes:   self-timed durations are plain defaults, not device figures
`ifndef FLASH_MAP_VH
`define FLASH_MAP_VH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_PAGE_READ       8'hD2
`define OP_BUF1_READ_FAST  8'hD4
`define OP_BUF1_READ_SLOW  8'hD1
`define OP_BUF2_READ_FAST  8'hD6
`define OP_BUF2_READ_SLOW  8'hD3
`define OP_BUF1_WRITE      8'h84
`define OP_BUF2_WRITE      8'h87
`define OP_BUF1_PROG_ERASE 8'h83
`define OP_BUF2_PROG_ERASE 8'h86
`define OP_BUF1_PROG       8'h88
`define OP_BUF2_PROG       8'h89
`define OP_PAGE_ERASE      8'h81

// ----------------------------------------
// header lengths in serial bits
// ----------------------------------------
`define HDR_ADDR_END       7'h20
`define HDR_PAGE_READ      7'h40
`define HDR_BUF_READ       7'h28

// ----------------------------------------
// address layout and geometry
// ----------------------------------------
`define STD_PAGE_LSB       9
`define BIN_PAGE_LSB       8
`define PAGE_NUM_W         12
`define PAGE_LEN_STD       9'h108
`define PAGE_LEN_BIN       9'h100
`define ERASED_BYTE        8'hFF

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ            100
`define EP_TIME_US         40000
`define P_TIME_US          3000
`define PE_TIME_US         35000
`define FIFO_DEPTH         16

`endif

// File: verilog/pin_sync.v
// Purpose: two-stage synchroniser for asynchronous pin inputs
// Assumes: inputs are plain levels from outside the clk domain
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module pin_sync #(
    parameter width = 3
) (
    input  wire             clk,   // system clock
    input  wire             nrst,  // sync reset, active low
    input  wire             ce,    // clock enable
    input  wire [width-1:0] d,     // asynchronous inputs
    output wire [width-1:0] q      // synchronised inputs
);
    reg [width-1:0] s1_q;
    reg [width-1:0] s2_q;

    always @(posedge clk) begin
        if (!nrst) begin
            s1_q <= {width{1'b1}};
            s2_q <= {width{1'b1}};
        end else if (ce) begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end

    assign q = s2_q;
endmodule

// File: verilog/sync_fifo.v
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   full and empty come from pointers with one extra wrap bit
`timescale 1ns/100ps
module sync_fifo #(
    parameter width = 18,
    parameter depth = 16,
    parameter aw    = 4
) (
    input  wire             clk,       // system clock
    input  wire             nrst,      // sync reset, active low
    input  wire             ce,        // clock enable
    input  wire             in_valid,  // write request
    output wire             in_ready,  // space available
    input  wire [width-1:0] in_data,   // write data
    output wire             out_valid, // data available
    input  wire             out_ready, // consumer takes head
    output wire [width-1:0] out_data   // head word
);
    reg [width-1:0] mem [0:depth-1];
    reg [aw:0]      wr_q;
    reg [aw:0]      rd_q;

    wire empty = (wr_q == rd_q);
    wire full  = (wr_q[aw] != rd_q[aw]) && (wr_q[aw-1:0] == rd_q[aw-1:0]);

    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rd_q[aw-1:0]];

    always @(posedge clk) begin
        if (!nrst) begin
            wr_q <= {(aw+1){1'b0}};
            rd_q <= {(aw+1){1'b0}};
        end else if (ce) begin
            if (in_valid && !full) begin
                mem[wr_q[aw-1:0]] <= in_data;
                wr_q              <= wr_q + 1'b1;
            end
            if (out_ready && !empty)
                rd_q <= rd_q + 1'b1;
        end
    end
endmodule

// File: verification/flash_page_ops_checker.sv
// Purpose: port-level assertions for the serial flash command block
// Assumes: link clock far below clk, ce held high
// Notes:   bound to every flash_page_ops instance
`timescale 1ns/100ps
module flash_page_ops_checker (
    input wire logic clk,           // system clock
    input wire logic nrst,          // sync reset, active low
    input wire logic ce,            // clock enable
    input wire logic cs_n,          // chip select pin
    input wire logic sck,           // serial clock pin
    input wire logic si,            // serial data in
    input wire logic bin_page_mode, // page size select
    input wire logic so,            // serial data out
    input wire logic so_oe,         // serial out enable
    input wire logic busy,          // self-timed op running
    input wire logic wr_stall       // write fifo full
);
    default clocking cb @(posedge clk);
    endclocking
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence s_cs_rise;
        $rose(cs_n);
    endsequence
    sequence s_oe_start;
        $rose(so_oe);
    endsequence
    sequence s_busy_run;
        busy [*8];
    endsequence

    a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !so_oe && !busy && !wr_stall)
        else $error("outputs active after reset");
    a_oe_release: assert property (disable iff (!nrst) s_cs_rise |-> ##[1:5] !so_oe)
        else $error("so_oe held after chip select rise");
    a_oe_idle: assert property (disable iff (!nrst) cs_n [*6] |-> !so_oe)
        else $error("so_oe high while deselected");
    a_oe_start: assert property (disable iff (!nrst) s_oe_start |-> !cs_n && sck)
        else $error("data phase began off a clock rise");
    a_oe_late: assert property (disable iff (!nrst) s_oe_start |-> !$past(cs_n, 8))
        else $error("data phase began too soon after select");
    a_so_on_fall: assert property (disable iff (!nrst)
        so_oe && $past(so_oe, 3) && $changed(so) |-> !sck)
        else $error("so changed while sck high");
    a_busy_cause: assert property (disable iff (!nrst) $rose(busy) |-> cs_n && $past(cs_n))
        else $error("busy rose inside a frame");
    a_busy_hold: assert property (disable iff (!nrst) $rose(busy) |=> s_busy_run)
        else $error("busy dropped too early");
    a_stall_busy: assert property (disable iff (!nrst) $rose(wr_stall) |-> busy)
        else $error("write fifo filled while idle");
endmodule

bind flash_page_ops flash_page_ops_checker i_chk (
    .clk(clk), .nrst(nrst), .ce(ce), .cs_n(cs_n), .sck(sck), .si(si), .bin_page_mode(bin_page_mode),
    .so(so), .so_oe(so_oe), .busy(busy), .wr_stall(wr_stall));

// File: verification/flash_host.sv
// Purpose: host controller model for the serial link, mode 0
// Assumes: sck half period of 8 clk, 160 ns period
// Notes:   si is inverted between frames so no stale bit lingers
`timescale 1ns/100ps
module flash_host (
    input  wire  clk,     // system clock
    input  wire  so,      // device serial out
    output logic cs_n,    // chip select, active low
    output logic sck,     // serial clock, idles low
    output logic si,      // serial data in
    output logic [7:0] rx // last captured byte
);
    event got;
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
        rx   = 8'h00;
    end
    // ----------------------------------------
    // frame tasks, entered at a clk edge
    // ----------------------------------------
    task automatic start();
        cs_n <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic xfer(input logic [7:0] tx, input bit cap);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            repeat (8) @(posedge clk);
            r = {r[6:0], so};
            sck <= 1'b1;
            repeat (8) @(posedge clk);
            sck <= 1'b0;
        end
        if (cap) begin
            rx = r;
            ->got;
        end
    endtask
    // cs stays low through the whole frame, released only here
    task automatic stop();
        repeat (8) @(posedge clk);
        cs_n <= 1'b1;
        si   <= ~si;
        repeat (24) @(posedge clk);
    endtask
endmodule

// File: verification/flash_page_ops_test.sv
// Purpose: self-checking bench for the serial flash command block
// Assumes: busy timers cut to 1000 cycles
// Notes:   reads push expected bytes, a monitor pops them per captured byte
`timescale 1ns/100ps
`include "flash_map.vh"
module flash_page_ops_test;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       bin = 1'b0;
    wire        cs_n, sck, si, so, so_oe, busy, wr_stall;
    wire  [7:0] rx;
    int         n_errors = 0;
    int         checks_done = 0;
    logic [7:0] exp_q[$];
    logic [7:0] bufm[2][264];
    logic [7:0] mem[int];

    always #5 clk = ~clk;

    flash_page_ops #(.ep_cycles(1000), .p_cycles(1000), .pe_cycles(1000)) i_dut (
        .clk(clk), .nrst(nrst), .ce(1'b1), .cs_n(cs_n), .sck(sck), .si(si), .bin_page_mode(bin),
        .so(so), .so_oe(so_oe), .busy(busy), .wr_stall(wr_stall));
    flash_host i_host (.clk(clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si), .rx(rx));

    // ----------------------------------------
    // compare and verdict
    // ----------------------------------------
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] want);
        checks_done++;
        if (got !== want) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic want);
        cmp_byte({7'h00, got}, {7'h00, want});
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(i_host.got) begin
        cmp_byte(rx, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    end

    // ----------------------------------------
    // command helpers
    // ----------------------------------------
    function automatic logic [23:0] adr(input logic [11:0] pg, input logic [8:0] off);
        return bin ? {4'h0, pg, off[7:0]} : {3'h0, pg, off};
    endfunction
    function automatic int sel(input logic [7:0] op);
        return int'(op == `OP_BUF2_WRITE || op == `OP_BUF2_PROG_ERASE || op == `OP_BUF2_PROG
            || op == `OP_BUF2_READ_FAST || op == `OP_BUF2_READ_SLOW);
    endfunction
    task automatic hdr(input logic [7:0] op, input logic [23:0] a, input int nd);
        i_host.start();
        i_host.xfer(op, 0);
        for (int i = 0; i < 3 + nd; i++)
            i_host.xfer(i < 3 ? a[23-8*i -: 8] : 8'h00, 0);
    endtask
    task automatic rd(input logic [7:0] op, input logic [11:0] pg, input logic [8:0] off, input int n);
        int o;
        hdr(op, adr(pg, off), op == `OP_PAGE_READ ? 4 : 1);
        cmp_flag(so_oe, 1'b1);
        for (int i = 0; i < n; i++) begin
            o = (int'(off) + i) % (bin ? 256 : 264);
            exp_q.push_back(op == `OP_PAGE_READ ? mem[int'(pg) * 512 + o] : bufm[sel(op)][o]);
            i_host.xfer(8'($urandom), 1);
        end
        i_host.stop();
        cmp_flag(so_oe, 1'b0);
    endtask
    task automatic wr(input logic [7:0] op, input logic [8:0] off, input int n);
        logic [7:0] d;
        hdr(op, adr(12'h000, off), 0);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            bufm[sel(op)][(int'(off) + i) % (bin ? 256 : 264)] = d;
            i_host.xfer(d, 0);
        end
        i_host.stop();
        cmp_flag(wr_stall, 1'b0);
    endtask
    task automatic wait_idle();
        int t;
        t = 0;
        while (busy !== 1'b0 && t < 5000) begin
            @(posedge clk);
            t++;
        end
        cmp_flag(busy, 1'b0);
    endtask
    // erase clears all 264 physical bytes, programming ANDs the buffer in
    task automatic pg_op(input logic [7:0] op, input logic [11:0] pg, input bit ers, input bit prg);
        hdr(op, adr(pg, 9'h000), 0);
        i_host.stop();
        for (int o = 0; o < 264; o++) begin
            if (ers)
                mem[int'(pg) * 512 + o] = 8'hFF;
            if (prg && o < (bin ? 256 : 264))
                mem[int'(pg) * 512 + o] &= bufm[sel(op)][o];
        end
        cmp_flag(busy, 1'b1);
        wait_idle();
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h0e371ab1));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        wr(`OP_BUF1_WRITE, 9'h106, 6);
        wr(`OP_BUF2_WRITE, 9'h000, 4);
        rd(`OP_BUF1_READ_FAST, 12'h000, 9'h106, 6);
        rd(`OP_BUF2_READ_SLOW, 12'h000, 9'h000, 4);
        pg_op(`OP_BUF1_PROG_ERASE, 12'hABC, 1, 1);
        rd(`OP_PAGE_READ, 12'hABC, 9'h106, 6);
        rd(`OP_BUF1_READ_SLOW, 12'h000, 9'h106, 6);
        pg_op(`OP_PAGE_ERASE, 12'hABC, 1, 0);
        rd(`OP_PAGE_READ, 12'hABC, 9'h105, 3);
        pg_op(`OP_BUF1_PROG, 12'hABC, 0, 1);
        rd(`OP_PAGE_READ, 12'hABC, 9'h106, 6);
        i_host.start();
        i_host.xfer(`OP_PAGE_ERASE, 0);
        i_host.xfer(8'h15, 0);
        i_host.xfer(8'h78, 0);
        i_host.stop();
        cmp_flag(busy, 1'b0);
        rd(`OP_PAGE_READ, 12'hABC, 9'h106, 6);
        bin <= 1'b1;
        repeat (2) @(posedge clk);
        wr(`OP_BUF2_WRITE, 9'h0FE, 4);
        rd(`OP_BUF2_READ_FAST, 12'h000, 9'h0FE, 4);
        pg_op(`OP_BUF2_PROG_ERASE, 12'h123, 1, 1);
        rd(`OP_PAGE_READ, 12'h123, 9'h0FE, 4);
        pg_op(`OP_PAGE_ERASE, 12'h123, 1, 0);
        pg_op(`OP_BUF2_PROG, 12'h123, 0, 1);
        rd(`OP_PAGE_READ, 12'h123, 9'h0FE, 4);
        repeat (20) @(posedge clk);
        print_verdict();
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
endmodule
